// File: mrq_core.sv
/*
 * Motion result queue and macro store.
 * Takes host function packets, stores them into four macro buffers or
 * passes them to the executor, queues deferred results and timed
 * snapshots of axis state. Assumes the executor and axis state are
 * synchronous to clk and a packet handshake is valid/ready.
 */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Deferred results go into the return queue
// - Snapshot count accepts zero to two hundred
// - Out-of-range parameters saturate, no error
// - Nine words: pos/vel per axis, then I/O
// - Samples back to back every 2.3 ms
// - Queue holds two hundred whole samples
// - Other results interleave among samples
// - Store start takes buffer one to four
// - While storing, packets stored not executed
// - Store end resumes execution at once
// - Stored packets run on trigger
// - Buffer sizes 1024,1024,1024,2048 packets
// - Buffer two may extend into three
// - No overflow check on buffer two
// - Nested store start flags function error
// - Queue is FIFO of axis, id, data; flushable
module mrq_core #(
    parameter int unsigned QUEUE_DEPTH = mrq_pkg::MAX_SNAPSHOTS
                                       * mrq_pkg::SAMPLE_WORDS,
    parameter int unsigned PERIOD_CYC  = mrq_pkg::SAMPLE_CYCLES
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Host function packets
    input  wire logic             pkt_valid,
    output logic                  pkt_ready,
    input  wire mrq_pkg::mrq_pkt_s pkt_in,
    // Packets to the executor
    output logic                  exec_valid,
    input  wire logic             exec_ready,
    output mrq_pkg::mrq_pkt_s     exec_pkt,
    // Deferred results from the executor
    input  wire logic             res_valid,
    output logic                  res_ready,
    input  wire mrq_pkg::mrq_ret_s res_in,
    // Live axis state and I/O port
    input  wire logic [31:0]      axis_pos [mrq_pkg::AXES],
    input  wire logic [31:0]      axis_vel [mrq_pkg::AXES],
    input  wire logic [15:0]      io_port,
    // Hardware trigger, already qualified by its enable
    input  wire logic [1:0]       trig_buf,
    input  wire logic             trig_fire,
    // Return-data queue read side
    output logic                  rdq_valid,
    input  wire logic             rdq_ready,
    output mrq_pkg::mrq_ret_s     rdq_data,
    output logic [15:0]           rdq_count,
    // Status
    output logic                  func_error,
    output logic                  storing,
    output logic                  capturing
);
    import mrq_pkg::*;

    localparam int CW = $clog2(QUEUE_DEPTH + 1);

    // A period no longer than one sample burst cannot be kept
    if (QUEUE_DEPTH < MAX_SNAPSHOTS * SAMPLE_WORDS
        || PERIOD_CYC <= SAMPLE_WORDS || CW > 16) begin : g_bad_params
        $error("mrq_core: bad parameters");
    end

    // Macro store as flip-flops, one packet per entry
    mrq_pkt_s    store_mem [int'(BUF_END)];
    logic [12:0] wr_ptr_q;
    logic [12:0] run_ptr_q;
    logic [12:0] fill_end_q [4];  // One past last stored packet
    logic [1:0]  store_sel_q;
    logic        store_q;
    logic        run_q;
    logic [12:0] run_end_q;
    logic        err_q;

    // Capture control
    mrq_cap_e    cap_q;
    logic [7:0]  left_q;
    logic [3:0]  word_q;
    logic [31:0] tick_q;

    // Return queue storage
    mrq_ret_s    q_mem [QUEUE_DEPTH];
    logic [CW-1:0] q_wr_q, q_rd_q, q_cnt_q;

    // Two-entry skid buffer in front of the executor
    mrq_pkt_s    sk_mem [2];
    logic        sk_wr_q, sk_rd_q;
    logic [1:0]  sk_cnt_q;

    // Packet decode
    logic is_begin, is_end, is_trig, is_acq, is_flush;
    assign is_begin = pkt_in.cmd == FN_BEGIN_PRE;
    assign is_end   = pkt_in.cmd == FN_END_PRE;
    assign is_trig  = pkt_in.cmd == FN_TRIG_IO;
    assign is_acq   = pkt_in.cmd == FN_ACQUIRE;
    assign is_flush = pkt_in.cmd == FN_FLUSH;

    logic sk_full, take, to_exec, run_push;
    assign sk_full  = sk_cnt_q == 2'd2;
    // Replay has priority; host stalls while a macro runs
    assign run_push = run_q && !sk_full;
    assign pkt_ready = !run_q && !sk_full;
    assign take     = pkt_valid && pkt_ready;
    // stored packets reach the executor only through replay
    assign to_exec  = take && !store_q && !is_acq && !is_flush
                      && !is_begin && !is_end && !is_trig;

    // Buffer base by number
    function automatic logic [12:0] base_of(input logic [1:0] n);
        case (n)
            2'd0:    base_of = BUF1_BASE;
            2'd1:    base_of = BUF2_BASE;
            2'd2:    base_of = BUF3_BASE;
            default: base_of = BUF4_BASE;
        endcase
    endfunction

    // Requested buffer number, clamped into one to four
    logic [1:0] req_sel;
    always_comb begin
        if (pkt_in.data[15:0] <= 16'h0001)
            req_sel = 2'd0;
        else if (pkt_in.data[15:0] >= 16'h0004)
            req_sel = 2'd3;
        else
            req_sel = 2'(pkt_in.data[15:0] - 16'h0001);
    end

    // Store mode and macro write pointer
    always_ff @(posedge clk) begin
        if (reset) begin
            store_q     <= 1'b0;
            store_sel_q <= 2'd0;
            wr_ptr_q    <= 13'h0000;
            err_q       <= 1'b0;
            for (int i = 0; i < 4; i++)
                fill_end_q[i] <= base_of(2'(i));
        end else if (take) begin
            err_q <= 1'b0;
            if (is_begin) begin
                if (store_q) begin
                    err_q <= 1'b1;
                end else begin
                    store_q     <= 1'b1;
                    store_sel_q <= req_sel;
                    wr_ptr_q    <= base_of(req_sel);
                end
            end else if (is_end && store_q) begin
                store_q <= 1'b0;
                fill_end_q[store_sel_q] <= wr_ptr_q;
            end else if (store_q && wr_ptr_q != BUF_END) begin
                // Buffer two runs on into three unchecked
                store_mem[wr_ptr_q] <= pkt_in;
                wr_ptr_q <= wr_ptr_q + 13'h0001;
            end
        end
    end

    // Macro replay on trigger
    always_ff @(posedge clk) begin
        if (reset) begin
            run_q     <= 1'b0;
            run_ptr_q <= 13'h0000;
            run_end_q <= 13'h0000;
        end else if (run_q) begin
            if (run_ptr_q == run_end_q)
                run_q <= 1'b0;
            else if (run_push)
                run_ptr_q <= run_ptr_q + 13'h0001;
        end else if (!store_q && trig_fire) begin
            run_q     <= 1'b1;
            run_ptr_q <= base_of(trig_buf);
            run_end_q <= fill_end_q[trig_buf];
        end else if (take && is_trig && !store_q) begin
            run_q     <= 1'b1;
            run_ptr_q <= base_of(req_sel);
            run_end_q <= fill_end_q[req_sel];
        end
    end

    // Executor skid buffer; a stall there holds back the host
    logic sk_push, sk_pop;
    mrq_pkt_s sk_in;
    assign sk_push = to_exec || (run_push && run_ptr_q != run_end_q);
    assign sk_in   = run_q ? store_mem[run_ptr_q] : pkt_in;
    assign sk_pop  = exec_valid && exec_ready;
    assign exec_valid = sk_cnt_q != 2'd0;
    assign exec_pkt   = sk_mem[sk_rd_q];
    always_ff @(posedge clk) begin
        if (reset) begin
            sk_wr_q  <= 1'b0;
            sk_rd_q  <= 1'b0;
            sk_cnt_q <= 2'd0;
        end else begin
            if (sk_push) begin
                sk_mem[sk_wr_q] <= sk_in;
                sk_wr_q <= !sk_wr_q;
            end
            if (sk_pop)
                sk_rd_q <= !sk_rd_q;
            sk_cnt_q <= sk_cnt_q + 2'(sk_push) - 2'(sk_pop);
        end
    end

    // Snapshot capture sequencer
    logic start_acq, cap_push;
    assign start_acq = take && is_acq && !store_q;
    assign cap_push  = cap_q == MRQ_WORDS && q_cnt_q != CW'(QUEUE_DEPTH);
    always_ff @(posedge clk) begin
        if (reset) begin
            cap_q  <= MRQ_IDLE;
            left_q <= 8'h00;
            word_q <= 4'h0;
            tick_q <= 32'h0000_0000;
        end else begin
            case (cap_q)
                MRQ_IDLE: begin
                    if (start_acq) begin
                        // Counts above the limit saturate
                        left_q <= (pkt_in.data[15:0] > 16'(MAX_SNAPSHOTS))
                                  ? 8'(MAX_SNAPSHOTS)
                                  : pkt_in.data[7:0];
                        tick_q <= 32'h0000_0000;
                        if (pkt_in.data[15:0] != 16'h0000)
                            cap_q <= MRQ_WORDS;
                    end
                end
                MRQ_WAIT: begin
                    if (tick_q >= 32'(PERIOD_CYC - 1)) begin
                        tick_q <= 32'h0000_0000;
                        cap_q  <= MRQ_WORDS;
                    end else begin
                        tick_q <= tick_q + 32'h0000_0001;
                    end
                end
                MRQ_WORDS: begin
                    tick_q <= tick_q + 32'h0000_0001;
                    if (cap_push) begin
                        if (word_q == 4'(SAMPLE_WORDS - 1)) begin
                            word_q <= 4'h0;
                            left_q <= left_q - 8'h01;
                            if (left_q == 8'h01)
                                cap_q <= MRQ_IDLE;
                            else
                                cap_q <= MRQ_WAIT;
                        end else begin
                            word_q <= word_q + 4'h1;
                        end
                    end
                end
                default: cap_q <= MRQ_IDLE;
            endcase
        end
    end

    // Snapshot word in fixed order
    mrq_ret_s cap_word;
    always_comb begin
        cap_word.axis = 8'(word_q[3:1] + 3'd1);
        cap_word.cmd  = FN_SAMPLE_ID;
        if (word_q == 4'(SAMPLE_WORDS - 1)) begin
            cap_word.axis = 8'h00;
            cap_word.data = {16'h0000, io_port};
        end else if (word_q[0]) begin
            cap_word.data = axis_vel[word_q[2:1]];
        end else begin
            cap_word.data = axis_pos[word_q[2:1]];
        end
    end

    // Return queue; samples win, results wait until the sample burst ends
    logic q_full, q_push, q_pop, flush;
    mrq_ret_s q_in;
    assign q_full   = q_cnt_q == CW'(QUEUE_DEPTH);
    assign res_ready = !q_full && !cap_push;
    assign q_push   = cap_push || (res_valid && res_ready);
    assign q_in     = cap_push ? cap_word : res_in;
    assign flush    = take && is_flush && !store_q;
    assign q_pop    = rdq_valid && rdq_ready;
    assign rdq_valid = q_cnt_q != '0;
    assign rdq_data  = q_mem[q_rd_q];
    assign rdq_count = 16'(q_cnt_q);
    always_ff @(posedge clk) begin
        if (reset || flush) begin
            q_wr_q  <= '0;
            q_rd_q  <= '0;
            q_cnt_q <= '0;
        end else begin
            if (q_push) begin
                q_mem[q_wr_q] <= q_in;
                q_wr_q <= (q_wr_q == CW'(QUEUE_DEPTH - 1)) ? '0
                          : q_wr_q + CW'(1);
            end
            if (q_pop)
                q_rd_q <= (q_rd_q == CW'(QUEUE_DEPTH - 1)) ? '0
                          : q_rd_q + CW'(1);
            q_cnt_q <= q_cnt_q + CW'(q_push) - CW'(q_pop);
        end
    end

    assign func_error = err_q;
    assign storing    = store_q;
    assign capturing  = cap_q != MRQ_IDLE;

endmodule
`default_nettype wire

// File: mrq_pkg.sv
/*
 * Package for the motion result queue and macro store block.
 * Holds function codes, packet carriers, sample layout, buffer sizes
 * and timing constants. Assumes a 40 MHz system clock.
 */
package mrq_pkg;

    // Clock rate and sampling period
    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned SAMPLE_PERIOD_NS = 2_300_000;
    localparam int unsigned SAMPLE_CYCLES   =
        (SAMPLE_PERIOD_NS / 1000) * (CLK_HZ / 1_000_000);

    // Capture limits and sample layout
    localparam int unsigned MAX_SNAPSHOTS   = 200;
    localparam int unsigned SAMPLE_WORDS    = 9;
    localparam int unsigned AXES            = 4;

    // Macro buffer sizes in packets (servo board)
    localparam int unsigned BUF1_PKTS       = 1024;
    localparam int unsigned BUF2_PKTS       = 1024;
    localparam int unsigned BUF2_EXT_PKTS   = 2048;
    localparam int unsigned BUF3_PKTS       = 1024;
    localparam int unsigned BUF4_PKTS       = 2048;
    localparam int unsigned BUF2_SAFE_FUNCS = 1000;
    localparam int unsigned BUF2_MAX_FUNCS  = 2000;

    // Base packet index of each buffer in the shared store
    localparam logic [12:0] BUF1_BASE = 13'h0000;
    localparam logic [12:0] BUF2_BASE = 13'h0400;
    localparam logic [12:0] BUF3_BASE = 13'h0800;
    localparam logic [12:0] BUF4_BASE = 13'h0c00;
    localparam logic [12:0] BUF_END   = 13'h1400;

    // Function identifiers handled by this block
    localparam logic [7:0] FN_ACQUIRE   = 8'h40;
    localparam logic [7:0] FN_BEGIN_PRE = 8'h41;
    localparam logic [7:0] FN_END_PRE   = 8'h42;
    localparam logic [7:0] FN_TRIG_IO   = 8'h43;
    localparam logic [7:0] FN_FLUSH     = 8'h44;
    localparam logic [7:0] FN_SAMPLE_ID = 8'h45;

    // Function packet: axis, function id, data, deferred-result flag
    typedef struct packed {
        logic [7:0]  axis;
        logic [7:0]  cmd;
        logic [31:0] data;
        logic        deferred;
    } mrq_pkt_s;

    // Return-data queue entry
    typedef struct packed {
        logic [7:0]  axis;
        logic [7:0]  cmd;
        logic [31:0] data;
    } mrq_ret_s;

    typedef enum logic [1:0] {
        MRQ_IDLE,
        MRQ_WAIT,
        MRQ_WORDS
    } mrq_cap_e;

endpackage

// File: mrq_core_asserts.sv
/*
 * Concurrent checks on the ports of mrq_core, bound into every instance.
 * Assumes one clock domain and a host that holds packets until taken.
 */
`timescale 1ns/1ps
`default_nettype none
module mrq_core_asserts
    import mrq_pkg::*;
#(
    parameter int unsigned QUEUE_DEPTH = 1800
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // Host packets
    input  wire logic              pkt_valid,
    input  wire logic              pkt_ready,
    input  wire mrq_pkg::mrq_pkt_s pkt_in,
    // Executor and return queue
    input  wire logic              exec_valid,
    input  wire logic              rdq_valid,
    input  wire logic              rdq_ready,
    input  wire mrq_pkg::mrq_ret_s rdq_data,
    input  wire logic [15:0]       rdq_count,
    // Status
    input  wire logic              func_error,
    input  wire logic              storing,
    input  wire logic              capturing
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Taken packet and its function code
    logic       tk;
    logic [7:0] cm;
    assign tk = pkt_valid && pkt_ready;
    assign cm = pkt_in.cmd;

    // Store mode entry, exit, nesting and silence of the executor
    a_begin_store: assert property (
        tk && cm == FN_BEGIN_PRE && !storing |=> storing)
        else $error("store mode not entered");
    a_store_quiet: assert property (
        storing [*6] |-> !exec_valid)
        else $error("packet executed while storing");
    a_end_store: assert property (
        tk && cm == FN_END_PRE && storing |=> !storing)
        else $error("store mode not left");
    a_nested_err: assert property (
        tk && cm == FN_BEGIN_PRE && storing |=> func_error && storing)
        else $error("nested begin not flagged");

    // Capture start, a zero count does nothing
    a_cap_start: assert property (
        tk && cm == FN_ACQUIRE && pkt_in.data[15:0] != 0 && !storing
        |-> ##[1:3] capturing)
        else $error("capture did not start");
    a_cap_zero: assert property (
        tk && cm == FN_ACQUIRE && pkt_in.data[15:0] == 0 && !storing
        && !capturing |=> !capturing)
        else $error("zero count started a capture");

    // Queue behaviour
    a_flush_empty: assert property (
        tk && cm == FN_FLUSH && !storing && !capturing
        |=> ##[0:1] (rdq_count == 0 && !rdq_valid))
        else $error("flush left entries");
    a_rdq_hold: assert property (
        rdq_valid && !rdq_ready && !(tk && cm == FN_FLUSH)
        |=> rdq_valid && $stable(rdq_data))
        else $error("queue head changed while stalled");
    a_queue_cap: assert property (rdq_count <= QUEUE_DEPTH)
        else $error("queue count above depth");

    // Main scenarios
    c_nested: cover property (tk && cm == FN_BEGIN_PRE && storing);
    c_cap_end: cover property ($fell(capturing));
    c_pop: cover property (rdq_valid && rdq_ready);
endmodule

bind mrq_core mrq_core_asserts #(.QUEUE_DEPTH(QUEUE_DEPTH))
    u_mrq_core_asserts (
    .clk(clk), .reset(reset), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
    .pkt_in(pkt_in), .exec_valid(exec_valid), .rdq_valid(rdq_valid),
    .rdq_ready(rdq_ready), .rdq_data(rdq_data), .rdq_count(rdq_count),
    .func_error(func_error), .storing(storing), .capturing(capturing));
`default_nettype wire

// File: mrq_exec_model.sv
/*
 * Behavioural executor beside mrq_core: logs every packet it takes and
 * answers each deferred packet with one result. Assumes clk and reset
 * of the block.
 */
`timescale 1ns/1ps
`default_nettype none
module mrq_exec_model
    import mrq_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // Stall every other cycle when set
    input  wire logic              slow,
    // Executor side of the block
    input  wire logic              exec_valid,
    output logic                   exec_ready,
    input  wire mrq_pkg::mrq_pkt_s exec_pkt,
    output logic                   res_valid,
    input  wire logic              res_ready,
    output mrq_pkg::mrq_ret_s      res_out
);
    mrq_pkt_s log_q [$];
    logic     tog_q;

    // Toggling ready exercises the skid buffer in front of us
    assign exec_ready = !slow || tog_q;

    // One result slot; the bench spaces deferred packets so none is lost
    always @(posedge clk) begin
        if (reset) begin
            tog_q <= 1'b0;
            res_valid <= 1'b0;
            res_out <= '0;
        end else begin
            tog_q <= !tog_q;
            if (res_valid && res_ready) begin
                res_valid <= 1'b0;
                res_out <= ~res_out; // Released lines show no stale value
            end
            if (exec_valid && exec_ready) begin
                log_q.push_back(exec_pkt);
                if (exec_pkt.deferred) begin
                    res_valid <= 1'b1;
                    res_out <= {exec_pkt.axis, exec_pkt.cmd, ~exec_pkt.data};
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: test_mrq_core.sv
/*
 * Self-checking bench for mrq_core with a behavioural executor.
 * Assumes a short sample period so full captures stay brief.
 */
`timescale 1ns/1ps
`default_nettype none
module test_mrq_core;
    import mrq_pkg::*;
    localparam int unsigned PER = 20;
    logic        clk, reset, pkt_valid, pkt_ready, exec_valid, exec_ready;
    logic        res_valid, res_ready, trig_fire, rdq_valid, rdq_ready;
    logic        func_error, storing, capturing, slow;
    logic [1:0]  trig_buf;
    logic [15:0] io_port, rdq_count;
    logic [31:0] axis_pos [AXES];
    logic [31:0] axis_vel [AXES];
    mrq_pkt_s    pkt_in, exec_pkt;
    mrq_ret_s    res_in, rdq_data;
    int          error_cnt, n_checks;

    mrq_core #(.PERIOD_CYC(PER)) u_mrq_core (.clk(clk), .reset(reset),
        .pkt_valid(pkt_valid), .pkt_ready(pkt_ready), .pkt_in(pkt_in),
        .exec_valid(exec_valid), .exec_ready(exec_ready),
        .exec_pkt(exec_pkt), .res_valid(res_valid), .res_ready(res_ready),
        .res_in(res_in), .axis_pos(axis_pos), .axis_vel(axis_vel),
        .io_port(io_port), .trig_buf(trig_buf), .trig_fire(trig_fire),
        .rdq_valid(rdq_valid), .rdq_ready(rdq_ready), .rdq_data(rdq_data),
        .rdq_count(rdq_count), .func_error(func_error), .storing(storing),
        .capturing(capturing));
    mrq_exec_model u_mrq_exec_model (.clk(clk), .reset(reset), .slow(slow),
        .exec_valid(exec_valid), .exec_ready(exec_ready),
        .exec_pkt(exec_pkt), .res_valid(res_valid), .res_ready(res_ready),
        .res_out(res_in));

    // Clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Step to just after the next rising edge
    task automatic tick();
        @(posedge clk);
        #2;
    endtask

    task automatic chk(input string nm, input logic [63:0] e, g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Packet is held until the edge that takes it
    task automatic send(input logic [7:0] c, input logic [31:0] d,
                        input logic df);
        tick();
        pkt_valid = 1'b1;
        pkt_in = '{axis: 8'h02, cmd: c, data: d, deferred: df};
        while (pkt_ready !== 1'b1)
            tick();
        tick();
        pkt_valid = 1'b0;
    endtask

    task automatic pop(output mrq_ret_s r);
        tick();
        rdq_ready = 1'b1;
        while (rdq_valid !== 1'b1)
            tick();
        r = rdq_data;
        tick();
        rdq_ready = 1'b0;
    endtask

    function automatic logic [63:0] exp_word(input int w);
        logic [31:0] d;
        d = (w % 2) ? 32'h2000_0000 : 32'h1000_0000;
        d = (w == 8) ? 32'h0000_5a5a : d + 32'(w / 2);
        return {16'h0, (w == 8) ? 8'h00 : 8'(w / 2 + 1), FN_SAMPLE_ID, d};
    endfunction

    task automatic t_defer();
        mrq_ret_s r;
        send(8'h21, 32'h1234_5678, 1'b1);
        send(8'h22, 32'h0000_00ff, 1'b1);
        repeat (10) tick();
        pop(r);
        chk("defer first", {16'h0, 8'h02, 8'h21, ~32'h1234_5678}, 64'(r));
        pop(r);
        chk("defer second", {16'h0, 8'h02, 8'h22, ~32'hff}, 64'(r));
        $display("t_defer done");
    endtask

    task automatic t_store(input int b, input int n, input logic hw);
        int base;
        int k;
        slow = !hw;
        chk("idle store", 64'h0, 64'(capturing));
        send(FN_BEGIN_PRE, 32'(b), 1'b0);
        send(FN_BEGIN_PRE, 32'h1, 1'b0);
        tick();
        chk("nested begin", 64'h1, 64'(func_error));
        chk("still storing", 64'h1, 64'(storing));
        base = u_mrq_exec_model.log_q.size();
        // Macros hold deferred variants only
        for (k = 0; k < n; k++)
            send(8'h30 + 8'(k), 32'(b * 16 + k), 1'b1);
        repeat (8) tick();
        chk("stored held", 64'(base), 64'(u_mrq_exec_model.log_q.size()));
        send(FN_END_PRE, 32'h0, 1'b0);
        chk("store ended", 64'h0, 64'(storing));
        send(8'h2f, 32'h0, 1'b0);
        repeat (4) tick();
        chk("run after end", 64'(base + 1), 64'(u_mrq_exec_model.log_q.size()));
        if (hw) begin
            trig_buf = 2'h3;
            trig_fire = 1'b1;
            tick();
            trig_fire = 1'b0;
        end else begin
            send(FN_TRIG_IO, 32'(b), 1'b0);
        end
        repeat (20) tick();
        for (k = 0; k < n; k++)
            chk("replay", {15'h0, 8'h02, 8'h30 + 8'(k), 32'(b * 16 + k), 1'b1},
                64'(u_mrq_exec_model.log_q[base + 1 + k]));
        send(FN_FLUSH, 32'h0, 1'b0);
        $display("t_store done");
    endtask

    task automatic t_cap_mix();
        send(FN_ACQUIRE, 32'd2, 1'b0);
        repeat (9) tick();
        chk("first sample", 64'd9, 64'(rdq_count));
        repeat (3) tick();
        send(8'h26, 32'h0, 1'b1);
        // Result lands in the gap; next sample not yet begun
        repeat (6) tick();
        chk("sample gap", 64'd10, 64'(rdq_count));
        repeat (54) tick();
        chk("mix stopped", 64'h0, 64'(capturing));
        chk("mix count", 64'd19, 64'(rdq_count));
        send(FN_FLUSH, 32'h0, 1'b0);
        tick();
        chk("flushed", 64'h0, 64'(rdq_count));
        send(FN_ACQUIRE, 32'd0, 1'b0);
        repeat (30) tick();
        chk("zero capture", 64'h0, 64'(rdq_count));
        $display("t_cap_mix done");
    endtask

    task automatic t_cap_full();
        mrq_ret_s r;
        int k;
        send(FN_ACQUIRE, 32'd300, 1'b0);
        // Host waits a scaled 3 ms per sample
        repeat (200 * 27) tick();
        chk("full stopped", 64'h0, 64'(capturing));
        chk("full count", 64'd1800, 64'(rdq_count));
        for (k = 0; k < 1800; k++) begin
            pop(r);
            chk("sample word", exp_word(k % 9), 64'(r));
        end
        tick();
        chk("drained", 64'h0, 64'(rdq_count));
        $display("t_cap_full done");
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        $display("FAIL watchdog expected done seen timeout");
        summarize();
    end

    // Main sequence
    initial begin
        error_cnt = 0;
        n_checks = 0;
        reset = 1'b1;
        {pkt_valid, trig_fire, rdq_ready, slow} = 4'h0;
        pkt_in = '0;
        trig_buf = 2'h0;
        io_port = 16'h5a5a;
        for (int i = 0; i < AXES; i++) begin
            axis_pos[i] = 32'h1000_0000 + 32'(i);
            axis_vel[i] = 32'h2000_0000 + 32'(i);
        end
        repeat (12) @(posedge clk);
        #2;
        reset = 1'b0;
        t_defer();
        t_store(2, 3, 1'b0);
        t_store(9, 1, 1'b1);
        t_cap_mix();
        t_cap_full();
        summarize();
    end
endmodule
`default_nettype wire
